// *** pkg/adcq_pkg.sv ***
package adcq_pkg;
   // Bus and table geometry
   localparam int ADDR_W  = 10;
   localparam int DATA_W  = 32;
   localparam int RES_W   = 10;
   localparam int CCW_W   = 10;
   localparam int NUM_CCW = 40;
   localparam int IDX_W   = 6;
   localparam int PRE_W   = 8;

   // Register byte offsets; tables sit in pages picked by addr[9:8]
   localparam logic [9:0] OFS_CLOCK    = 10'h000;
   localparam logic [9:0] OFS_Q1_CTL   = 10'h004;
   localparam logic [9:0] OFS_Q2_CTL   = 10'h008;
   localparam logic [9:0] OFS_STATUS   = 10'h00C;
   localparam logic [1:0] PAGE_CCW     = 2'h1;
   localparam logic [1:0] PAGE_RESULT  = 2'h2;

   // Command word fields
   localparam int CW_CHAN_LSB  = 0;
   localparam int CW_IST_LSB   = 6;
   localparam int CW_BYP_BIT   = 8;
   localparam int CW_PAUSE_BIT = 9;

   // Queue control fields
   localparam int QC_MODE_LSB   = 0;
   localparam int QC_SSE_BIT    = 2;
   localparam int QC_RESUME_BIT = 3;
   localparam int QC_BQ2_LSB    = 8;

   // Status fields
   localparam int ST_DONE_LSB  = 0;
   localparam int ST_PAUSE_LSB = 2;
   localparam int ST_OVR_LSB   = 4;
   localparam int ST_Q1_LSB    = 6;
   localparam int ST_Q2_LSB    = 9;
   localparam int ST_PTR_LSB   = 12;

   // Reset values
   localparam logic [PRE_W-1:0] RST_PRESCALE = 8'h07;
   localparam logic [IDX_W-1:0] RST_BQ2      = 6'h28;

   // Channel codes
   localparam logic [IDX_W-1:0] END_OF_QUEUE_CODE      = 6'h3F;
   localparam logic [IDX_W-1:0] REFERENCE_HIGH_CHANNEL = 6'h3C;
   localparam logic [IDX_W-1:0] REFERENCE_LOW_CHANNEL  = 6'h3D;
   localparam logic [IDX_W-1:0] HALF_SUPPLY_CHANNEL    = 6'h3E;
   localparam logic [IDX_W-1:0] NUM_PINS               = 6'h10;

   // Phase lengths in conversion clocks, and the least clock divisor
   localparam logic [3:0]       INIT_TICKS    = 4'h2;
   localparam logic [3:0]       XFER_TICKS    = 4'h4;
   localparam logic [3:0]       RESOLVE_BITS  = 4'hA;
   localparam logic [PRE_W-1:0] MIN_DIV       = 8'h03;

   typedef enum logic [1:0] {MODE_OFF, MODE_SW_SINGLE, MODE_EXT_SINGLE, MODE_EXT_CONT} adcq_mode_e;
   typedef enum logic [2:0] {QS_IDLE, QS_ACTIVE, QS_PAUSED, QS_PENDING, QS_SUSPENDED} adcq_qstate_e;
   typedef enum logic [2:0] {PH_IDLE, PH_FETCH, PH_INIT, PH_XFER, PH_FINAL, PH_RESOLVE} adcq_phase_e;

   // Analog front-end controls
   typedef struct packed {
      logic [IDX_W-1:0] chan;
      logic             route;
      logic             init_sample;
      logic             transfer;
      logic             final_sample;
      logic             resolve;
      logic [RES_W-1:0] trial;
   } adcq_fe_s;
endpackage

// *** rtl/adcq_top.sv ***
// What this block does
// - Conversion runs initial, transfer, final, resolve phases
// - Initial two ticks, transfer four ticks
// - Final sample 2, 4, 8, 16 ticks
// - Resolution takes ten ticks, one bit each
// - Bypass skips initial and transfer phases
// - Bits decided MSB first from comparator
// - Finished result written to result table
// - Route sixteen pins or three reference channels
// - Forty-word command table, one or two queues
// - Idle sequencer starts a triggered queue at once
// - Queue two trigger pends behind queue one
// - Queue one trigger suspends running queue two
// - Suspended queue two resumes per resume bit
// - Simultaneous triggers: queue one runs, two pends
// - Pause bit word ends subqueue, sets pause
// - After pause continue only at next word
// - Trigger during execution only sets overrun
// - Continuous scan restarts at first word
// - Mode picks trigger; scan type whole queue
// - Channel 63 ends queue without conversion
// - End of queue beats pause on one word
// - Single scan clears arm bit at completion
//
// Chosen here: the placing of the registers and strobed register access.
module adcq_top (
   input  wire logic                        clk_i,
   input  wire logic                        srst_i,
   input  wire logic [adcq_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [adcq_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                        wr_i,
   input  wire logic                        rd_i,
   output logic      [adcq_pkg::DATA_W-1:0] rdata_o,
   input  wire logic [1:0]                  ext_trig_i,
   input  wire logic                        comp_i,
   output adcq_pkg::adcq_fe_s               fe_o
);
   logic [adcq_pkg::PRE_W-1:0] prescale;
   logic [adcq_pkg::PRE_W-1:0] div_cnt;
   logic [adcq_pkg::PRE_W-1:0] div_top;
   logic                       tick;
   logic [1:0]                 trig_s1;
   logic [1:0]                 trig_s2;
   logic [1:0]                 trig_d;
   logic                       comp_s1;
   logic                       comp_s2;
   adcq_pkg::adcq_mode_e       mode [2];
   adcq_pkg::adcq_qstate_e     qst [2];
   logic [adcq_pkg::IDX_W-1:0] ptr [2];
   logic [adcq_pkg::IDX_W-1:0] bq2;
   logic [adcq_pkg::IDX_W-1:0] sub2;
   logic                       resume;
   logic [1:0]                 single_scan_arm;
   logic [1:0]                 evt;
   logic [1:0]                 req;
   logic [1:0]                 done;
   logic [1:0]                 paused;
   logic [1:0]                 ovr;
   logic [1:0]                 set_done;
   logic [1:0]                 set_pause;
   logic [1:0]                 set_ovr;
   logic                       run;
   logic                       cq;
   adcq_pkg::adcq_phase_e      ph;
   logic [3:0]                 cnt;
   logic [3:0]                 bitn;
   logic [adcq_pkg::RES_W-1:0] sar;
   logic [adcq_pkg::CCW_W-1:0] word;
   logic [adcq_pkg::CCW_W-1:0] ccw_mem [adcq_pkg::NUM_CCW];
   logic [adcq_pkg::RES_W-1:0] res_mem [adcq_pkg::NUM_CCW];

   // Final sample ticks minus one from the sample-time select field
   function automatic logic [3:0] final_last(input logic [adcq_pkg::CCW_W-1:0] w);
      final_last = 4'((5'h02 << w[adcq_pkg::CW_IST_LSB +: 2]) - 5'h01);
   endfunction

   // Bus decode
   logic       wr_clk;
   logic       wr_q1;
   logic       wr_q2;
   logic       wr_st;
   logic       ccw_hit;
   logic       res_hit;
   logic [5:0] bus_idx;
   assign bus_idx = addr_i[7:2];
   assign wr_clk  = wr_i && addr_i == adcq_pkg::OFS_CLOCK;
   assign wr_q1   = wr_i && addr_i == adcq_pkg::OFS_Q1_CTL;
   assign wr_q2   = wr_i && addr_i == adcq_pkg::OFS_Q2_CTL;
   assign wr_st   = wr_i && addr_i == adcq_pkg::OFS_STATUS;
   assign ccw_hit = addr_i[9:8] == adcq_pkg::PAGE_CCW && addr_i[1:0] == 2'h0
                    && bus_idx < 6'(adcq_pkg::NUM_CCW);
   assign res_hit = addr_i[9:8] == adcq_pkg::PAGE_RESULT && addr_i[1:0] == 2'h0
                    && bus_idx < 6'(adcq_pkg::NUM_CCW);

   // Conversion clock enable; short divisors are stretched for comparator latency
   assign div_top = (prescale < adcq_pkg::MIN_DIV) ? adcq_pkg::MIN_DIV : prescale;
   assign tick    = div_cnt == 8'h00;
   always_ff @(posedge clk_i)
   begin
      if (srst_i || tick)
         div_cnt <= srst_i ? adcq_pkg::RST_PRESCALE : div_top;
      else
         div_cnt <= div_cnt - 8'h01;
   end

   // Pin synchronisers
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         {trig_s1, trig_s2, trig_d} <= 6'h00;
         {comp_s1, comp_s2}         <= 2'h0;
      end
      else
      begin
         trig_s1 <= ext_trig_i;
         trig_s2 <= trig_s1;
         trig_d  <= trig_s2;
         comp_s1 <= comp_i;
         comp_s2 <= comp_s1;
      end
   end

   // Current command word and queue bounds
   logic [adcq_pkg::IDX_W-1:0] cur_ptr;
   logic [adcq_pkg::IDX_W-1:0] q_end;
   logic [adcq_pkg::IDX_W-1:0] q_beg;
   logic [adcq_pkg::CCW_W-1:0] fw;
   logic                       end_of_queue_code;
   assign cur_ptr = ptr[cq];
   assign q_end   = cq ? 6'(adcq_pkg::NUM_CCW) : bq2;
   assign q_beg   = cq ? bq2 : 6'h00;
   assign fw      = (cur_ptr < 6'(adcq_pkg::NUM_CCW)) ? ccw_mem[cur_ptr]
                    : {4'h0, adcq_pkg::END_OF_QUEUE_CODE};
   assign end_of_queue_code     = cur_ptr >= q_end
                    || fw[adcq_pkg::CW_CHAN_LSB +: 6] == adcq_pkg::END_OF_QUEUE_CODE;

   // Queue arbitration terms
   logic go0;
   logic go1;
   logic busy1;
   logic wait1;
   logic start1;
   logic hold1;
   logic step;
   assign busy1  = qst[1] == adcq_pkg::QS_ACTIVE || wait1;
   assign wait1  = qst[1] == adcq_pkg::QS_PENDING || qst[1] == adcq_pkg::QS_SUSPENDED;
   assign go0    = req[0] && qst[0] != adcq_pkg::QS_ACTIVE;
   assign go1    = req[1] && !busy1;
   assign start1 = !go0 && !run && (go1 || wait1);
   assign hold1  = go1 && !start1;
   assign step   = tick && run && !go0;

   // Resolution and result store
   logic [adcq_pkg::RES_W-1:0] next_sar;
   logic                       res_we;
   assign next_sar = sar | (comp_s2 ? (10'h001 << bitn) : 10'h000);
   assign res_we   = step && ph == adcq_pkg::PH_RESOLVE && bitn == 4'h0;

   // Trigger sources and flag events per queue
   for (genvar q = 0; q < 2; q++)
   begin : g_queue
      logic edge_seen;
      logic sw_mode;
      assign edge_seen = trig_s2[q] & ~trig_d[q];
      assign sw_mode   = mode[q] == adcq_pkg::MODE_SW_SINGLE;
      assign evt[q]    = sw_mode ? single_scan_arm[q] && (qst[q] == adcq_pkg::QS_IDLE || qst[q] == adcq_pkg::QS_PAUSED)
                       : mode[q] == adcq_pkg::MODE_EXT_SINGLE ? edge_seen && single_scan_arm[q]
                       : mode[q] == adcq_pkg::MODE_EXT_CONT && edge_seen;
      assign set_ovr[q]   = tick && req[q] && !sw_mode
                            && (q == 0 ? qst[0] == adcq_pkg::QS_ACTIVE : busy1);
      assign set_done[q]  = step && cq == 1'(q) && ph == adcq_pkg::PH_FETCH && end_of_queue_code;
      assign set_pause[q] = res_we && cq == 1'(q) && word[adcq_pkg::CW_PAUSE_BIT];
   end

   // Trigger latch between ticks and sticky flags; set wins over clear
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         {req, done, paused, ovr} <= 8'h00;
      else
      begin
         req    <= (req & ~{2{tick}}) | evt;
         done   <= (done & ~(wr_st ? wdata_i[adcq_pkg::ST_DONE_LSB +: 2] : 2'h0)) | set_done;
         paused <= (paused & ~(wr_st ? wdata_i[adcq_pkg::ST_PAUSE_LSB +: 2] : 2'h0)) | set_pause;
         ovr    <= (ovr & ~(wr_st ? wdata_i[adcq_pkg::ST_OVR_LSB +: 2] : 2'h0)) | set_ovr;
      end
   end

   // Software control fields
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         prescale <= adcq_pkg::RST_PRESCALE;
         mode     <= '{adcq_pkg::MODE_OFF, adcq_pkg::MODE_OFF};
         resume   <= 1'b0;
         bq2      <= adcq_pkg::RST_BQ2;
      end
      else
      begin
         if (wr_clk)
            prescale <= wdata_i[adcq_pkg::PRE_W-1:0];
         if (wr_q1)
            mode[0] <= adcq_pkg::adcq_mode_e'(wdata_i[adcq_pkg::QC_MODE_LSB +: 2]);
         if (wr_q2)
         begin
            mode[1] <= adcq_pkg::adcq_mode_e'(wdata_i[adcq_pkg::QC_MODE_LSB +: 2]);
            resume  <= wdata_i[adcq_pkg::QC_RESUME_BIT];
            bq2     <= wdata_i[adcq_pkg::QC_BQ2_LSB +: 6];
         end
      end
   end

   // Command and result tables
   always_ff @(posedge clk_i)
   begin
      if (wr_i && ccw_hit)
         ccw_mem[bus_idx] <= wdata_i[adcq_pkg::CCW_W-1:0];
      if (res_we)
         res_mem[cur_ptr] <= next_sar;
   end

   // Queue sequencer and conversion phases
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         qst  <= '{adcq_pkg::QS_IDLE, adcq_pkg::QS_IDLE};
         ptr  <= '{6'h00, 6'h00};
         sub2 <= 6'h00;
         single_scan_arm  <= 2'h0;
         run  <= 1'b0;
         cq   <= 1'b0;
         ph   <= adcq_pkg::PH_IDLE;
         cnt  <= 4'h0;
         bitn <= 4'h0;
         sar  <= 10'h000;
         word <= 10'h000;
      end
      else
      begin
         if (tick && go0)
         begin
            if (run && cq)
            begin
               qst[1] <= adcq_pkg::QS_SUSPENDED;
               ptr[1] <= resume ? sub2 : bq2;
            end
            if (qst[0] == adcq_pkg::QS_IDLE)
               ptr[0] <= 6'h00;
            qst[0] <= adcq_pkg::QS_ACTIVE;
            run    <= 1'b1;
            cq     <= 1'b0;
            ph     <= adcq_pkg::PH_FETCH;
         end
         if (tick && (hold1 || (start1 && go1)))
         begin
            if (qst[1] == adcq_pkg::QS_IDLE)
            begin
               ptr[1] <= bq2;
               sub2   <= bq2;
            end
            else
               sub2 <= ptr[1];
            if (hold1)
               qst[1] <= adcq_pkg::QS_PENDING;
         end
         if (tick && start1)
         begin
            qst[1] <= adcq_pkg::QS_ACTIVE;
            run    <= 1'b1;
            cq     <= 1'b1;
            ph     <= adcq_pkg::PH_FETCH;
         end
         if (step)
         begin
            case (ph)
               adcq_pkg::PH_FETCH:
                  if (end_of_queue_code)
                  begin
                     qst[cq] <= adcq_pkg::QS_IDLE;
                     ptr[cq] <= q_beg;
                     run     <= 1'b0;
                     ph      <= adcq_pkg::PH_IDLE;
                     if (mode[cq] != adcq_pkg::MODE_EXT_CONT)
                        single_scan_arm[cq] <= 1'b0;
                  end
                  else
                  begin
                     word <= fw;
                     ph   <= fw[adcq_pkg::CW_BYP_BIT] ? adcq_pkg::PH_FINAL : adcq_pkg::PH_INIT;
                     cnt  <= fw[adcq_pkg::CW_BYP_BIT] ? final_last(fw) : adcq_pkg::INIT_TICKS - 4'h1;
                  end
               adcq_pkg::PH_INIT:
                  if (cnt == 4'h0)
                  begin
                     ph  <= adcq_pkg::PH_XFER;
                     cnt <= adcq_pkg::XFER_TICKS - 4'h1;
                  end
                  else
                     cnt <= cnt - 4'h1;
               adcq_pkg::PH_XFER:
                  if (cnt == 4'h0)
                  begin
                     ph  <= adcq_pkg::PH_FINAL;
                     cnt <= final_last(word);
                  end
                  else
                     cnt <= cnt - 4'h1;
               adcq_pkg::PH_FINAL:
                  if (cnt == 4'h0)
                  begin
                     ph   <= adcq_pkg::PH_RESOLVE;
                     bitn <= adcq_pkg::RESOLVE_BITS - 4'h1;
                     sar  <= 10'h000;
                  end
                  else
                     cnt <= cnt - 4'h1;
               adcq_pkg::PH_RESOLVE:
               begin
                  sar <= next_sar;
                  if (bitn == 4'h0)
                  begin
                     ptr[cq] <= cur_ptr + 6'h01;
                     if (word[adcq_pkg::CW_PAUSE_BIT])
                     begin
                        qst[cq] <= adcq_pkg::QS_PAUSED;
                        run     <= 1'b0;
                        ph      <= adcq_pkg::PH_IDLE;
                     end
                     else
                        ph <= adcq_pkg::PH_FETCH;
                  end
                  else
                     bitn <= bitn - 4'h1;
               end
               default:
                  ph <= adcq_pkg::PH_IDLE;
            endcase
         end
         if (wr_q1)
            single_scan_arm[0] <= wdata_i[adcq_pkg::QC_SSE_BIT];
         if (wr_q2)
            single_scan_arm[1] <= wdata_i[adcq_pkg::QC_SSE_BIT];
      end
   end

   // Front-end controls, registered
   adcq_pkg::adcq_fe_s   next_fe;
   logic [5:0]           wchan;
   logic                 sampling;
   assign wchan    = word[adcq_pkg::CW_CHAN_LSB +: 6];
   assign sampling = ph == adcq_pkg::PH_INIT || ph == adcq_pkg::PH_XFER || ph == adcq_pkg::PH_FINAL;
   assign next_fe.chan         = wchan;
   assign next_fe.route        = sampling && (wchan < adcq_pkg::NUM_PINS
                                 || wchan == adcq_pkg::REFERENCE_HIGH_CHANNEL
                                 || wchan == adcq_pkg::REFERENCE_LOW_CHANNEL
                                 || wchan == adcq_pkg::HALF_SUPPLY_CHANNEL);
   assign next_fe.init_sample  = ph == adcq_pkg::PH_INIT;
   assign next_fe.transfer     = ph == adcq_pkg::PH_XFER;
   assign next_fe.final_sample = ph == adcq_pkg::PH_FINAL;
   assign next_fe.resolve      = ph == adcq_pkg::PH_RESOLVE;
   assign next_fe.trial        = next_fe.resolve ? (sar | (10'h001 << bitn)) : 10'h000;

   // Read mux; data stands only in the cycle after the strobe
   logic [31:0] status;
   logic [31:0] next_rdata;
   assign status = 32'(done) << adcq_pkg::ST_DONE_LSB | 32'(paused) << adcq_pkg::ST_PAUSE_LSB
                 | 32'(ovr) << adcq_pkg::ST_OVR_LSB | 32'(qst[0]) << adcq_pkg::ST_Q1_LSB
                 | 32'(qst[1]) << adcq_pkg::ST_Q2_LSB | 32'(cur_ptr) << adcq_pkg::ST_PTR_LSB;
   assign next_rdata = !rd_i ? 32'h0 
                     : addr_i == adcq_pkg::OFS_CLOCK ? 32'(prescale)
                     : addr_i == adcq_pkg::OFS_Q1_CTL ? 32'(mode[0])
                     : addr_i == adcq_pkg::OFS_Q2_CTL ? 32'(mode[1]) | 32'(resume) << adcq_pkg::QC_RESUME_BIT
                                                         | 32'(bq2) << adcq_pkg::QC_BQ2_LSB
                     : addr_i == adcq_pkg::OFS_STATUS ? status
                     : ccw_hit ? 32'(ccw_mem[bus_idx])
                     : res_hit ? 32'(res_mem[bus_idx]) : 32'h0;

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         rdata_o <= 32'h0;
         fe_o    <= '0;
      end
      else
      begin
         rdata_o <= next_rdata;
         fe_o    <= next_fe;
      end
   end

   // Phase length checker helper
   adcq_pkg::adcq_phase_e ph_d;
   logic [4:0]            span;
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         ph_d <= adcq_pkg::PH_IDLE;
         span <= 5'h00;
      end
      else
      begin
         ph_d <= ph;
         span <= (ph != ph_d) ? 5'h00 : span + 5'(tick);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   sequence s_fetch_byp;
      step && ph == adcq_pkg::PH_FETCH && !end_of_queue_code && fw[adcq_pkg::CW_BYP_BIT];
   endsequence
   sequence s_fetch_eoq;
      step && ph == adcq_pkg::PH_FETCH && end_of_queue_code;
   endsequence

   a_init_len: assert property ($past(ph) == adcq_pkg::PH_INIT && ph == adcq_pkg::PH_XFER |-> $past(span) == 5'h01)
      else $error("initial sample length wrong");
   a_xfer_len: assert property ($past(ph) == adcq_pkg::PH_XFER && ph == adcq_pkg::PH_FINAL |-> $past(span) == 5'h03)
      else $error("transfer length wrong");
   a_final_len: assert property ($past(ph) == adcq_pkg::PH_FINAL && ph == adcq_pkg::PH_RESOLVE
      |-> $past(span) == 5'(final_last(word)))
      else $error("final sample length wrong");
   a_resolve_len: assert property ($past(ph) == adcq_pkg::PH_RESOLVE && ph != adcq_pkg::PH_RESOLVE && !$past(go0)
      |-> $past(span) == 5'h09)
      else $error("resolution length wrong");
   a_bypass_skip: assert property (s_fetch_byp |=> (ph == adcq_pkg::PH_FINAL) [*2])
      else $error("bypass did not skip to final sample");
   a_msb_first: assert property (step && ph == adcq_pkg::PH_RESOLVE && bitn != 4'h0 |=> bitn == $past(bitn) - 4'h1)
      else $error("trial bit order wrong");
   a_result_store: assert property (res_we |=> res_mem[$past(cur_ptr)] == $past(next_sar))
      else $error("result not stored at word index");
   a_eoq_idle: assert property (s_fetch_eoq |=> !run && ph == adcq_pkg::PH_IDLE && done[$past(cq)]
      && (!paused[$past(cq)] || $past(paused[cq])))
      else $error("end of queue not handled");
   a_abort_q2: assert property (tick && go0 && run && cq |=> qst[1] == adcq_pkg::QS_SUSPENDED && !cq)
      else $error("queue two not suspended");
   a_pend_q2: assert property (tick && go1 && (go0 || (run && !cq)) |=> qst[1] == adcq_pkg::QS_PENDING)
      else $error("queue two trigger not pending");
   a_trig_ovr: assert property (tick && req[0] && qst[0] == adcq_pkg::QS_ACTIVE && mode[0] != adcq_pkg::MODE_SW_SINGLE
      |=> ovr[0] && qst[0] == adcq_pkg::QS_ACTIVE)
      else $error("overrun not flagged");
endmodule

// *** dv/adcq_fe_model.sv ***
module adcq_fe_model (
   input  wire logic               clk_i,
   input  adcq_pkg::adcq_fe_s      fe_i,
   output logic                    comp_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Analog level of the routed channel: code and a fixed tail
   wire logic [9:0] level = {fe_i.chan, 4'hA};

   logic            wander = 1'b0;

   // Idle noise on the comparator output outside resolution
   always @(posedge clk_i)
   begin
      wander <= ~wander;
   end

   // Comparator answers at once, like the analog part; wanders otherwise
   assign comp_o = fe_i.resolve ? (level >= fe_i.trial) : wander;
endmodule

// *** dv/testbench.sv ***
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 4; // Clocks per conversion tick with divider 3
   logic                clk_i      = 1'b0;
   logic                srst_i     = 1'b1;
   logic [9:0]          addr_i     = 10'h000;
   logic [31:0]         wdata_i    = 32'h0;
   logic                wr_i       = 1'b0;
   logic                rd_i       = 1'b0;
   logic [1:0]          ext_trig_i = 2'h0;
   logic [31:0]         rdata_o;
   logic                comp_i;
   adcq_pkg::adcq_fe_s  fe_o;
   int                  n_fail     = 0;
   int                  n_compared = 0;
   int                  cyc        = 0;
   int                  c_in, c_xf, c_fn, c_rs;
   logic [31:0]         d;

   adcq_top uut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .ext_trig_i(ext_trig_i), .comp_i(comp_i), .fe_o(fe_o));
   adcq_fe_model fe (.clk_i(clk_i), .fe_i(fe_o), .comp_o(comp_i));

   initial
   begin
      forever #2 clk_i = ~clk_i;
   end

   // Phase length counters and run ceiling
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      c_in <= c_in + int'(fe_o.init_sample);
      c_xf <= c_xf + int'(fe_o.transfer);
      c_fn <= c_fn + int'(fe_o.final_sample);
      c_rs <= c_rs + int'(fe_o.resolve);
      if (cyc == 40000)
      begin
         n_fail++;
         report_and_stop();
      end
   end

   function automatic logic [31:0] lvl(input logic [5:0] ch);
      return {22'h0, ch, 4'hA};
   endfunction

   task automatic report_and_stop();
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [9:0] a, output logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask

   task automatic rchk(input logic [9:0] a, input logic [31:0] exp, input string m);
      rd(a, d);
      chk(d, exp, m);
   endtask

   // Poll status until the masked field matches, bounded
   task automatic wait_st(input logic [31:0] mask, input logic [31:0] val);
      for (int i = 0; i < 300; i++)
      begin
         rd(adcq_pkg::OFS_STATUS, d);
         if ((d & mask) === val)
            break;
      end
      chk(d & mask, val, "status");
   endtask

   task automatic trig(input logic [1:0] m);
      @(posedge clk_i);
      ext_trig_i <= m;
      repeat (8) @(posedge clk_i);
      ext_trig_i <= 2'h0;
   endtask

   task automatic cw(input int i, input logic [31:0] v);
      wr(10'h100 + 10'(4 * i), v);
   endtask

   task automatic reset_values();
      rchk(adcq_pkg::OFS_CLOCK, 32'h7, "prescale");
      rchk(adcq_pkg::OFS_Q2_CTL, 32'h2800, "q2 ctl");
      rchk(adcq_pkg::OFS_STATUS, 32'h0, "status");
      rchk(10'h010, 32'h0, "unmapped");
      wr(adcq_pkg::OFS_CLOCK, 32'h3);
      wr(adcq_pkg::OFS_Q2_CTL, 32'h300);
   endtask

   // One software scan of word 0 then end of queue; expected phase lengths in ticks
   task automatic conv(input logic [31:0] w, input int ei, input int ex, input int ef);
      int b_in, b_xf, b_fn, b_rs;
      wr(adcq_pkg::OFS_STATUS, 32'h3F);
      cw(0, w);
      cw(1, 32'h3F);
      b_in = c_in;
      b_xf = c_xf;
      b_fn = c_fn;
      b_rs = c_rs;
      wr(adcq_pkg::OFS_Q1_CTL, 32'h5);
      wait_st(32'h1C1, 32'h1);
      chk(32'(c_in - b_in), 32'(ei * TK), "initial");
      chk(32'(c_xf - b_xf), 32'(ex * TK), "transfer");
      chk(32'(c_fn - b_fn), 32'(ef * TK), "final");
      chk(32'(c_rs - b_rs), 32'(10 * TK), "resolve");
      rchk(10'h200, lvl(w[5:0]), "result");
   endtask

   task automatic pause_scan();
      wr(adcq_pkg::OFS_STATUS, 32'h3F);
      cw(0, 32'h201);
      cw(1, 32'h002);
      cw(2, 32'h3F);
      wr(adcq_pkg::OFS_Q1_CTL, 32'h6);
      trig(2'h1);
      repeat (20) @(posedge clk_i);
      trig(2'h1);
      wait_st(32'h1FC, 32'h94);
      rchk(10'h200, lvl(6'h01), "result 0");
      trig(2'h1);
      wait_st(32'h1C1, 32'h1);
      rchk(10'h204, lvl(6'h02), "result 1");
   endtask

   task automatic priority_scan();
      wr(adcq_pkg::OFS_STATUS, 32'h3F);
      cw(0, 32'h001);
      cw(1, 32'h3F);
      cw(3, 32'h007);
      cw(4, 32'h3F);
      wr(adcq_pkg::OFS_Q2_CTL, 32'h306);
      wr(adcq_pkg::OFS_Q1_CTL, 32'h6);
      trig(2'h3);
      wait_st(32'hFC0, 32'h640);
      wait_st(32'hFC3, 32'h3);
      rchk(10'h20C, lvl(6'h07), "result 3");
   endtask

   // Queue one trigger while queue two converts; queue two restarts after
   task automatic suspend_scan();
      wr(adcq_pkg::OFS_STATUS, 32'h3F);
      cw(0, 32'h002);
      cw(3, 32'h009);
      wr(adcq_pkg::OFS_Q2_CTL, 32'h306);
      wr(adcq_pkg::OFS_Q1_CTL, 32'h6);
      trig(2'h2);
      wait_st(32'hFC0, 32'h200);
      trig(2'h1);
      wait_st(32'hFC0, 32'h840);
      wait_st(32'hFC3, 32'h3);
      rchk(10'h200, lvl(6'h02), "result 0");
      rchk(10'h20C, lvl(6'h09), "result 3");
   endtask

   // Continuous scan: second edge starts again at word 0
   task automatic cont_scan();
      wr(adcq_pkg::OFS_STATUS, 32'h3F);
      cw(0, 32'h003);
      wr(adcq_pkg::OFS_Q1_CTL, 32'h3);
      trig(2'h1);
      wait_st(32'h1C1, 32'h1);
      wr(adcq_pkg::OFS_STATUS, 32'h3F);
      cw(0, 32'h004);
      trig(2'h1);
      wait_st(32'h1C1, 32'h1);
      rchk(10'h200, lvl(6'h04), "restart");
   endtask

   task automatic pause_eoq();
      int b_fn;
      wr(adcq_pkg::OFS_STATUS, 32'h3F);
      cw(0, 32'h23F);
      b_fn = c_fn;
      wr(adcq_pkg::OFS_Q1_CTL, 32'h5);
      wait_st(32'h1CF, 32'h1);
      chk(32'(c_fn - b_fn), 32'h0, "no conversion");
   endtask

   initial
   begin
      repeat (12) @(posedge clk_i);
      srst_i <= 1'b0;
      reset_values();
      conv(32'h045, 2, 4, 4);
      conv(32'h1BC, 0, 0, 8);
      pause_scan();
      priority_scan();
      suspend_scan();
      cont_scan();
      pause_eoq();
      report_and_stop();
   end
endmodule
